// ===== sfr_bank1_pkg.sv
`default_nettype none
package sfr_bank1_pkg;

  // ----------------------------------------------------------------
  // register offsets, bank 1 view
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INDIRECT = 8'h80;
  localparam logic [7:0] OFS_OPTION = 8'h81;
  localparam logic [7:0] OFS_PC_LOW = 8'h82;
  localparam logic [7:0] OFS_STATUS = 8'h83;
  localparam logic [7:0] OFS_POINTER = 8'h84;
  localparam logic [7:0] OFS_DIR_A = 8'h85;
  localparam logic [7:0] OFS_DIR_B = 8'h86;
  localparam logic [7:0] OFS_DIR_C = 8'h87;
  localparam logic [7:0] OFS_PCLATCH = 8'h8a;
  localparam logic [7:0] OFS_INTCTL = 8'h8b;
  localparam logic [7:0] OFS_PIE = 8'h8c;
  localparam logic [7:0] OFS_PWRCAUSE = 8'h8e;
  localparam logic [7:0] OFS_T2PER = 8'h92;
  localparam logic [7:0] OFS_SSPADDR = 8'h93;
  localparam logic [7:0] OFS_SSPSTATE = 8'h94;
  localparam logic [7:0] OFS_ADCFG = 8'h9f;

  // ----------------------------------------------------------------
  // reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_DIR_A = 8'h3f;
  localparam logic [7:0] RST_DIR_BC = 8'hff;
  localparam logic [7:0] RST_T2PER = 8'hff;
  localparam logic [7:0] RST_STATUS_POR = 8'h18;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MASK_DIR_A = 8'h3f;
  localparam logic [7:0] MASK_PCLATCH = 8'h1f;
  localparam logic [7:0] MASK_PIE = 8'h4f;
  localparam logic [7:0] MASK_ADCFG = 8'h07;
  localparam logic [1:0] PWR_AFTER_POR = 2'h0;
  localparam logic [1:0] PWR_AFTER_BROWNOUT = 2'h2;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_Z = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_BANK_LO = 5;
  localparam int ST_BANK_HI = 6;
  localparam int ST_IND_BANK = 7;

  typedef enum logic [1:0] {
    CAUSE_POR = 2'h0,
    CAUSE_BROWNOUT = 2'h1,
    CAUSE_EXT = 2'h3,
    CAUSE_WDT = 2'h2
  } rst_cause_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } core_req_s;

  typedef struct packed {
    logic [2:0] upd;
    logic zero;
    logic halfCarry;
    logic carry;
    logic isSub;
  } alu_flags_s;

  typedef struct packed {
    logic wdtClear;
    logic sleepEntry;
    logic wdtTimeout;
    logic [2:0] intFlagSet;
  } core_events_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [7:0] data;
  } ext_req_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] option;
    logic [7:0] dirA;
    logic [7:0] dirB;
    logic [7:0] dirC;
    logic [7:0] intCtl;
    logic [7:0] pieEn;
    logic [7:0] t2Period;
    logic [7:0] sspAddr;
    logic [1:0] sspCtl;
    logic [7:0] adCfg;
    logic [1:0] pwrCause;
  } sfr_cfg_s;

endpackage
`default_nettype wire

// ===== sfr_bank1.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// R1 - flag-affecting status writes take alu flags
// R2 - timeout and powerdown flags are read-only
// R3 - clearing status zeroes bank bits, sets zero
// R4 - software alters status with non-flag instructions
// R5 - subtraction stores carries as no-borrow
// R6 - software keeps reserved bank bits clear
// R7 - shared core registers decode in all four banks
// R8 - indirect port accesses location under pointer
// R9 - program counter low write applies latch bits
// R10 - every reset makes all port pins inputs
// R11 - power-up and other resets differ
// R12 - unimplemented addresses and bits read zero
// R13 - software keeps converter bits zero
// R14 - bank-1 registers need bank 1 selected
module sfr_bank1 (
  input wire logic clk_sys,
  input wire logic rst,
  input wire sfr_bank1_pkg::rst_cause_e rstCause,
  input wire sfr_bank1_pkg::core_req_s req,
  input wire sfr_bank1_pkg::alu_flags_s alu,
  input wire sfr_bank1_pkg::core_events_s events,
  input wire logic [7:0] pcLowIn,
  input wire logic [5:0] serialStatus,
  input wire logic [7:0] extRdData,
  output logic [7:0] rdData,
  output sfr_bank1_pkg::ext_req_s ext,
  output logic pcLoad,
  output logic [12:0] pcTarget,
  output sfr_bank1_pkg::sfr_cfg_s cfg
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] edgeOpt_reg;
  logic [7:0] pointer_reg;
  logic [7:0] dirA_reg;
  logic [7:0] dirB_reg;
  logic [7:0] dirC_reg;
  logic [7:0] pcLatch_reg;
  logic [7:0] intCtl_reg;
  logic [7:0] pieEn_reg;
  logic [1:0] pwrCause_reg;
  logic [7:0] t2Period_reg;
  logic [7:0] sspAddr_reg;
  logic [1:0] sspCtl_reg;
  logic [7:0] adCfg_reg;
  logic [7:0] rdLocal_reg;
  logic extPending_reg;
  logic pcLoad_reg;
  logic [12:0] pcTarget_reg;

  logic indirect;
  logic [8:0] effAddr;
  logic [7:0] effLow;
  logic bank1Region;
  logic localHit;
  logic [7:0] localVal;
  logic wrShared;
  logic wrBank1;
  logic powerUp;

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  // indirect uses the pointer plus the indirect bank bit
  assign indirect = (req.addr == sfr_bank1_pkg::OFS_INDIRECT[6:0]);
  assign effAddr = indirect ? {status_reg[sfr_bank1_pkg::ST_IND_BANK], pointer_reg} // R8
                            : {status_reg[sfr_bank1_pkg::ST_BANK_HI],
                               status_reg[sfr_bank1_pkg::ST_BANK_LO], req.addr};
  // compare against printed bank-1 offsets
  assign effLow = {1'b1, effAddr[6:0]};
  assign bank1Region = (effAddr[8:7] == 2'b01) && (effAddr[6:5] == 2'b00); // R14
  assign powerUp = (rstCause == sfr_bank1_pkg::CAUSE_POR) ||
                   (rstCause == sfr_bank1_pkg::CAUSE_BROWNOUT);

  // read mux; shared registers answer in any bank
  always_comb begin
    localHit = 1'b0;
    localVal = 8'h00;
    case (effLow)
      sfr_bank1_pkg::OFS_INDIRECT: begin
        localHit = 1'b1; // pointer aimed at itself reads zero
      end
      sfr_bank1_pkg::OFS_PC_LOW: begin
        localHit = 1'b1; // R7
        localVal = pcLowIn;
      end
      sfr_bank1_pkg::OFS_STATUS: begin
        localHit = 1'b1; // R7
        localVal = status_reg;
      end
      sfr_bank1_pkg::OFS_POINTER: begin
        localHit = 1'b1; // R7
        localVal = pointer_reg;
      end
      sfr_bank1_pkg::OFS_PCLATCH: begin
        localHit = 1'b1; // R7
        localVal = pcLatch_reg & sfr_bank1_pkg::MASK_PCLATCH;
      end
      sfr_bank1_pkg::OFS_INTCTL: begin
        localHit = 1'b1; // R7
        localVal = intCtl_reg;
      end
      default: begin
        if (bank1Region) begin
          localHit = 1'b1; // R12
          case (effLow)
            sfr_bank1_pkg::OFS_OPTION: localVal = edgeOpt_reg;
            sfr_bank1_pkg::OFS_DIR_A: localVal = dirA_reg & sfr_bank1_pkg::MASK_DIR_A;
            sfr_bank1_pkg::OFS_DIR_B: localVal = dirB_reg;
            sfr_bank1_pkg::OFS_DIR_C: localVal = dirC_reg;
            sfr_bank1_pkg::OFS_PIE: localVal = pieEn_reg & sfr_bank1_pkg::MASK_PIE;
            sfr_bank1_pkg::OFS_PWRCAUSE: localVal = {6'h00, pwrCause_reg};
            sfr_bank1_pkg::OFS_T2PER: localVal = t2Period_reg;
            sfr_bank1_pkg::OFS_SSPADDR: localVal = sspAddr_reg;
            sfr_bank1_pkg::OFS_SSPSTATE: localVal = {sspCtl_reg, serialStatus};
            sfr_bank1_pkg::OFS_ADCFG: localVal = adCfg_reg & sfr_bank1_pkg::MASK_ADCFG;
            default: localVal = 8'h00; // R12
          endcase
        end
      end
    endcase
  end

  assign wrShared = req.wr && localHit;
  assign wrBank1 = req.wr && bank1Region;

  // everything outside this map goes to data memory
  assign ext.rd = req.rd && !localHit;
  assign ext.wr = req.wr && !localHit;
  assign ext.addr = effAddr;
  assign ext.data = req.data;

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdLocal_reg <= 8'h00;
      extPending_reg <= 1'b0;
    end else begin
      rdLocal_reg <= req.rd ? localVal : 8'h00;
      extPending_reg <= ext.rd;
    end
  end

  // memory answers combinationally in the cycle after its strobe
  assign rdData = extPending_reg ? extRdData : rdLocal_reg;

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  // a flag-affecting instruction drops all three written flag bits
  always_comb begin
    status_next = status_reg;
    if (wrShared && effLow == sfr_bank1_pkg::OFS_STATUS) begin
      status_next = {req.data[7:5], status_reg[4:3], req.data[2:0]}; // R2
      if (alu.upd != 3'b000) begin
        status_next[2:0] = status_reg[2:0]; // R1 R3
      end
    end
    if (alu.upd[2]) begin
      status_next[sfr_bank1_pkg::ST_Z] = alu.zero; // R1 R3
    end
    if (alu.upd[1]) begin
      status_next[sfr_bank1_pkg::ST_HALF_CARRY] = alu.halfCarry ^ alu.isSub; // R1 R5
    end
    if (alu.upd[0]) begin
      status_next[sfr_bank1_pkg::ST_C] = alu.carry ^ alu.isSub; // R1 R5
    end
    // only the watchdog and sleep logic touch these two
    if (events.wdtTimeout) begin
      status_next[sfr_bank1_pkg::ST_TIMEOUT] = 1'b0;
    end else if (events.sleepEntry) begin
      status_next[sfr_bank1_pkg::ST_TIMEOUT] = 1'b1;
      status_next[sfr_bank1_pkg::ST_PWRDN] = 1'b0;
    end else if (events.wdtClear) begin
      status_next[sfr_bank1_pkg::ST_TIMEOUT] = 1'b1;
      status_next[sfr_bank1_pkg::ST_PWRDN] = 1'b1;
    end
  end

  // other resets keep the alu flags and pd
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      if (powerUp) begin
        status_reg <= sfr_bank1_pkg::RST_STATUS_POR; // R11
      end else begin
        status_reg <= {3'b000,
                       status_reg[sfr_bank1_pkg::ST_TIMEOUT] &&
                       (rstCause != sfr_bank1_pkg::CAUSE_WDT),
                       status_reg[3:0]}; // R11
      end
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // shared registers: pointer, pc latch, interrupt control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      if (powerUp) begin
        pointer_reg <= sfr_bank1_pkg::RST_ZERO; // R11
      end
    end else if (wrShared && effLow == sfr_bank1_pkg::OFS_POINTER) begin
      pointer_reg <= req.data; // R8
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcLatch_reg <= sfr_bank1_pkg::RST_ZERO;
    end else if (wrShared && effLow == sfr_bank1_pkg::OFS_PCLATCH) begin
      pcLatch_reg <= req.data & sfr_bank1_pkg::MASK_PCLATCH; // R12
    end
  end

  // event set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      intCtl_reg <= powerUp ? sfr_bank1_pkg::RST_ZERO : {7'h00, intCtl_reg[0]}; // R11
    end else if (wrShared && effLow == sfr_bank1_pkg::OFS_INTCTL) begin
      intCtl_reg <= {req.data[7:3], req.data[2:0] | events.intFlagSet};
    end else begin
      intCtl_reg <= {intCtl_reg[7:3], intCtl_reg[2:0] | events.intFlagSet};
    end
  end

  // pc upper bits only reach the counter through the latch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcLoad_reg <= 1'b0;
      pcTarget_reg <= 13'h0000;
    end else begin
      pcLoad_reg <= wrShared && effLow == sfr_bank1_pkg::OFS_PC_LOW; // R9
      pcTarget_reg <= {pcLatch_reg[4:0], req.data}; // R9
    end
  end

  assign pcLoad = pcLoad_reg;
  assign pcTarget = pcTarget_reg;

  // ----------------------------------------------------------------
  // bank-1-only registers
  // ----------------------------------------------------------------
  // port directions go to input on every reset kind
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dirA_reg <= sfr_bank1_pkg::RST_DIR_A; // R10
      dirB_reg <= sfr_bank1_pkg::RST_DIR_BC; // R10
      dirC_reg <= sfr_bank1_pkg::RST_DIR_BC; // R10
    end else if (wrBank1) begin
      if (effLow == sfr_bank1_pkg::OFS_DIR_A) begin
        dirA_reg <= req.data & sfr_bank1_pkg::MASK_DIR_A;
      end
      if (effLow == sfr_bank1_pkg::OFS_DIR_B) begin
        dirB_reg <= req.data;
      end
      if (effLow == sfr_bank1_pkg::OFS_DIR_C) begin
        dirC_reg <= req.data;
      end
    end
  end

  // plain configuration bytes, same value for every reset kind
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edgeOpt_reg <= sfr_bank1_pkg::RST_OPTION;
      pieEn_reg <= sfr_bank1_pkg::RST_ZERO;
      t2Period_reg <= sfr_bank1_pkg::RST_T2PER;
      sspAddr_reg <= sfr_bank1_pkg::RST_ZERO;
      sspCtl_reg <= 2'b00;
      adCfg_reg <= sfr_bank1_pkg::RST_ZERO;
    end else if (wrBank1) begin
      if (effLow == sfr_bank1_pkg::OFS_OPTION) begin
        edgeOpt_reg <= req.data; // R14
      end
      if (effLow == sfr_bank1_pkg::OFS_PIE) begin
        pieEn_reg <= req.data & sfr_bank1_pkg::MASK_PIE; // R12
      end
      if (effLow == sfr_bank1_pkg::OFS_T2PER) begin
        t2Period_reg <= req.data;
      end
      if (effLow == sfr_bank1_pkg::OFS_SSPADDR) begin
        sspAddr_reg <= req.data;
      end
      if (effLow == sfr_bank1_pkg::OFS_SSPSTATE) begin
        sspCtl_reg <= req.data[7:6]; // low six bits follow the serial port
      end
      if (effLow == sfr_bank1_pkg::OFS_ADCFG) begin
        adCfg_reg <= req.data & sfr_bank1_pkg::MASK_ADCFG; // R12
      end
    end
  end

  // reset cause flags: cleared by their reset, set by software
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      if (rstCause == sfr_bank1_pkg::CAUSE_POR) begin
        pwrCause_reg <= sfr_bank1_pkg::PWR_AFTER_POR; // R11
      end else if (rstCause == sfr_bank1_pkg::CAUSE_BROWNOUT) begin
        pwrCause_reg <= sfr_bank1_pkg::PWR_AFTER_BROWNOUT; // R11
      end
    end else if (wrBank1 && effLow == sfr_bank1_pkg::OFS_PWRCAUSE) begin
      pwrCause_reg <= req.data[1:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs to the core and peripherals
  // ----------------------------------------------------------------
  assign cfg.status = status_reg;
  assign cfg.option = edgeOpt_reg;
  assign cfg.dirA = dirA_reg;
  assign cfg.dirB = dirB_reg;
  assign cfg.dirC = dirC_reg;
  assign cfg.intCtl = intCtl_reg;
  assign cfg.pieEn = pieEn_reg;
  assign cfg.t2Period = t2Period_reg;
  assign cfg.sspAddr = sspAddr_reg;
  assign cfg.sspCtl = sspCtl_reg;
  assign cfg.adCfg = adCfg_reg;
  assign cfg.pwrCause = pwrCause_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_readonly_a: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (req.wr && localHit && effLow == sfr_bank1_pkg::OFS_STATUS &&
     events == '0) |=> $stable(status_reg[4:3]))
    else $error("timeout or powerdown flag changed by a write");

  zero_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    alu.upd[2] |=> status_reg[sfr_bank1_pkg::ST_Z] == $past(alu.zero))
    else $error("zero flag does not follow the alu");

  borrow_polarity_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (alu.upd[0] && alu.isSub) |=> status_reg[sfr_bank1_pkg::ST_C] == !$past(alu.carry))
    else $error("carry not inverted on subtraction");

  clear_status_a: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (wrShared && effLow == sfr_bank1_pkg::OFS_STATUS && req.data == 8'h00 &&
     alu.upd == 3'b100 && alu.zero && events == '0)
    |=> status_reg[7:5] == 3'b000 && status_reg[2] &&
    $stable({status_reg[4:3], status_reg[1:0]}))
    else $error("clearing status gave a wrong value");

  pc_load_a: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (wrShared && effLow == sfr_bank1_pkg::OFS_PC_LOW)
    |=> pcLoad && pcTarget == {$past(pcLatch_reg[4:0]), $past(req.data)})
    else $error("pc load target wrong");

  dir_reset_a: assert property (@(posedge clk_sys) disable iff (rst) // R10
    $fell(rst) |-> dirA_reg == 8'h3f && dirB_reg == 8'hff && dirC_reg == 8'hff)
    else $error("port directions not inputs after reset");

  por_status_a: assert property (@(posedge clk_sys) disable iff (rst) // R11
    ($fell(rst) && $past(rstCause) == sfr_bank1_pkg::CAUSE_POR) |-> status_reg == 8'h18)
    else $error("power-up status value wrong");

  unimpl_read_a: assert property (@(posedge clk_sys) disable iff (rst) // R12
    (req.rd && !indirect && status_reg[6:5] == 2'b01 &&
     (req.addr == 7'h08 || req.addr == 7'h0d || req.addr == 7'h15)) |=> rdData == 8'h00)
    else $error("unimplemented address read nonzero");

  mirror_read_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (req.rd && req.addr == 7'h03) |=> rdData == $past(status_reg))
    else $error("status not readable in this bank");

  indirect_path_a: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (req.rd && indirect && !localHit) |-> ext.rd && ext.addr[7:0] == pointer_reg)
    else $error("indirect access missed the pointer");

  bank_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
    (req.rd && !indirect && status_reg[6:5] == 2'b00 &&
     (req.addr == 7'h01 || req.addr == 7'h05)) |-> ext.rd)
    else $error("bank-1 register answered in bank 0");

endmodule
`default_nettype wire

// ===== sfr_bank1_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sfr_bank1_tb;
  // ------------------------------------------------------------
  // signals around the register bank
  // ------------------------------------------------------------
  logic clk_sys;
  logic rst;
  sfr_bank1_pkg::rst_cause_e rstCause;
  sfr_bank1_pkg::rst_cause_e cause;
  sfr_bank1_pkg::core_req_s req;
  sfr_bank1_pkg::alu_flags_s alu;
  sfr_bank1_pkg::alu_flags_s f;
  sfr_bank1_pkg::core_events_s events;
  logic [7:0] pcLowIn;
  logic [5:0] serialStatus;
  logic [7:0] extRdData;
  logic [7:0] rdData;
  sfr_bank1_pkg::ext_req_s ext;
  logic pcLoad;
  logic [12:0] pcTarget;
  sfr_bank1_pkg::sfr_cfg_s cfg;
  int n_mismatch;
  int cmp_count;
  logic [7:0] st;
  logic [7:0] est;
  logic [7:0] v;
  logic [7:0] d;
  logic [7:0] p;
  logic [7:0] ib;
  logic [7:0] pcv;
  logic [1:0] pw;
  logic por;

  // holes in the bank 1 map, and writable places with their masks
  localparam logic [6:0] UNIMP [16] = '{7'h08, 7'h09, 7'h0d, 7'h0f, 7'h10, 7'h11, 7'h15,
    7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e};
  localparam logic [6:0] RWA [10] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h0a, 7'h0b, 7'h0c,
    7'h12, 7'h13, 7'h1f};
  // write masks keep the converter enable and pin config at zero
  localparam logic [7:0] WMASK [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hbf,
    8'hff, 8'hff, 8'hf8};
  localparam logic [7:0] RMASK [10] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h4f,
    8'hff, 8'hff, 8'h07};
  localparam sfr_bank1_pkg::rst_cause_e CAUSES [4] = '{sfr_bank1_pkg::CAUSE_BROWNOUT,
    sfr_bank1_pkg::CAUSE_EXT, sfr_bank1_pkg::CAUSE_WDT, sfr_bank1_pkg::CAUSE_POR};

  sfr_bank1 DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .rstCause(rstCause),
    .req(req),
    .alu(alu),
    .events(events),
    .pcLowIn(pcLowIn),
    .serialStatus(serialStatus),
    .extRdData(extRdData),
    .rdData(rdData),
    .ext(ext),
    .pcLoad(pcLoad),
    .pcTarget(pcTarget),
    .cfg(cfg)
  );

  // free-running core clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // expected status after a write, alu flags winning over written data
  function automatic logic [7:0] st_exp(input logic [7:0] old, input logic [7:0] wd,
    input sfr_bank1_pkg::alu_flags_s af);
    logic [7:0] e;
    e = {wd[7:5], old[4:3], (af.upd != 3'b000) ? old[2:0] : wd[2:0]};
    if (af.upd[2]) e[2] = af.zero;
    if (af.upd[1]) e[1] = af.halfCarry ^ af.isSub;
    if (af.upd[0]) e[0] = af.carry ^ af.isSub;
    return e;
  endfunction

  // one bus cycle; reads compare against exp or against the data memory answer
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] wd,
    input sfr_bank1_pkg::alu_flags_s af, input logic extExp, input logic [8:0] eadr,
    input logic [7:0] exp);
    logic [7:0] xd;
    xd = 8'($urandom);
    @(posedge clk_sys);
    req.rd <= !w;
    req.wr <= w;
    req.addr <= a;
    req.data <= wd;
    alu <= af;
    pcLowIn <= pcv;
    #1;
    chk(16'({ext.rd, ext.wr}), 16'(extExp ? {!w, w} : 2'b00), "ext strobes");
    if (extExp) chk(16'(ext.addr), 16'(eadr), "ext address");
    if (extExp && w) chk(16'(ext.data), 16'(wd), "ext write data");
    @(posedge clk_sys);
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    alu <= '0;
    extRdData <= xd;
    #1;
    if (!w) chk(16'(rdData), 16'(extExp ? xd : exp), "read data");
  endtask

  task automatic do_reset(input sfr_bank1_pkg::rst_cause_e c, input int n);
    @(posedge clk_sys);
    rst <= 1'b1;
    rstCause <= c;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
  endtask

  task automatic chk_rst;
    chk({cfg.dirA, cfg.dirB}, 16'h3fff, "port a and b direction");
    chk({cfg.dirC, cfg.option}, 16'hffff, "port c direction and options");
    chk({cfg.t2Period, cfg.pieEn}, 16'hff00, "period and irq enables");
    chk({cfg.sspAddr, cfg.adCfg}, 16'h0000, "slave address and pin config");
    chk(16'({rdData, pcLoad}), 16'h0000, "read data and pc load in reset");
  endtask

  // bounded run: a hang ends as a failure
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    $display("mismatch at %0t: run timed out", $time);
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rstCause = sfr_bank1_pkg::CAUSE_POR;
    req = '0;
    alu = '0;
    events = '0;
    pcLowIn = 8'h00;
    extRdData = 8'h00;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(32'h369c));
    serialStatus = 6'($urandom);
    pcv = 8'($urandom);
    do_reset(sfr_bank1_pkg::CAUSE_POR, 20);
    chk_rst();
    chk({cfg.status, 6'h00, cfg.pwrCause}, 16'h1800, "power-up status and cause");
    st = 8'h18;
    pw = 2'b00;
    // bank 0: bank-1-only place goes out, shared ones stay local
    access(1'b0, 7'h05, 8'h00, '0, 1'b1, {2'b00, 7'h05}, 8'h00);
    access(1'b0, 7'h02, 8'h00, '0, 1'b0, 9'h000, pcv);
    // pointer kept inside bank 0 general memory so the indirect access leaves the map
    p = {3'b001, 5'($urandom)};
    access(1'b1, 7'h04, p, '0, 1'b0, 9'h000, 8'h00);
    v = 8'($urandom);
    access(1'b1, 7'h00, v, '0, 1'b1, {1'b0, p}, 8'h00);
    access(1'b0, 7'h00, 8'h00, '0, 1'b1, {1'b0, p}, 8'h00);
    // bank 1, with zeros written to the read-only flags
    access(1'b1, 7'h03, 8'h20, '0, 1'b0, 9'h000, 8'h00);
    st = st_exp(st, 8'h20, '0);
    access(1'b0, 7'h03, 8'h00, '0, 1'b0, 9'h000, st);
    access(1'b0, 7'h04, 8'h00, '0, 1'b0, 9'h000, p);
    access(1'b0, 7'h02, 8'h00, '0, 1'b0, 9'h000, pcv);
    foreach (UNIMP[i]) begin
      access(1'b1, UNIMP[i], 8'($urandom), '0, 1'b0, 9'h000, 8'h00);
      access(1'b0, UNIMP[i], 8'h00, '0, 1'b0, 9'h000, 8'h00);
    end
    foreach (RWA[i]) begin
      v = 8'($urandom) & WMASK[i];
      access(1'b1, RWA[i], v, '0, 1'b0, 9'h000, 8'h00);
      access(1'b0, RWA[i], 8'h00, '0, 1'b0, 9'h000, v & RMASK[i]);
    end
    // serial state: upper two bits stored, lower six live from the port
    access(1'b1, 7'h14, v, '0, 1'b0, 9'h000, 8'h00);
    access(1'b0, 7'h14, 8'h00, '0, 1'b0, 9'h000, {v[7:6], serialStatus});
    // low byte write hands the latch bits to the program counter
    v = 8'($urandom);
    d = 8'($urandom);
    access(1'b1, 7'h0a, v, '0, 1'b0, 9'h000, 8'h00);
    access(1'b1, 7'h02, d, '0, 1'b0, 9'h000, 8'h00);
    chk(16'({pcLoad, pcTarget}), 16'({1'b1, v[4:0], d}), "pc load and target");
    @(posedge clk_sys);
    #1;
    chk(16'(pcLoad), 16'h0000, "pc load lasts one cycle");
    // flag-affecting writes, subtraction among them
    for (int i = 0; i < 8; i++) begin
      f = sfr_bank1_pkg::alu_flags_s'($urandom);
      if (i == 0) f.upd = 3'b111;
      if (i == 0) f.isSub = 1'b1;
      v = {3'b001, 5'($urandom)};
      access(1'b1, 7'h03, v, f, 1'b0, 9'h000, 8'h00);
      st = st_exp(st, v, f);
      access(1'b0, 7'h03, 8'h00, '0, 1'b0, 9'h000, st);
    end
    // clear of status: bank bits zero, zero flag set, other flags kept
    access(1'b1, 7'h03, 8'h23, '0, 1'b0, 9'h000, 8'h00);
    st = st_exp(st, 8'h23, '0);
    f = '0;
    f.upd = 3'b100;
    f.zero = 1'b1;
    access(1'b1, 7'h03, 8'h00, f, 1'b0, 9'h000, 8'h00);
    st = st_exp(st, 8'h00, f);
    access(1'b0, 7'h03, 8'h00, '0, 1'b0, 9'h000, st);
    // sleep entry and watchdog clear move the two flags; the timeout event is held low throughout
    @(posedge clk_sys);
    events.sleepEntry <= 1'b1;
    @(posedge clk_sys);
    events <= '0;
    #1;
    chk(16'(cfg.status), 16'({st[7:4], 1'b0, st[2:0]}), "status after sleep");
    @(posedge clk_sys);
    events.wdtClear <= 1'b1;
    @(posedge clk_sys);
    events <= '0;
    #1;
    chk(16'(cfg.status), 16'(st), "status after watchdog clear");
    // every kind of reset, with state to keep or lose
    for (int k = 0; k < 4; k++) begin
      cause = CAUSES[k];
      p = 8'($urandom);
      ib = 8'($urandom);
      access(1'b1, 7'h04, p, '0, 1'b0, 9'h000, 8'h00);
      access(1'b1, 7'h0b, ib, '0, 1'b0, 9'h000, 8'h00);
      access(1'b1, 7'h03, 8'h23, '0, 1'b0, 9'h000, 8'h00);
      st = st_exp(st, 8'h23, '0);
      access(1'b1, 7'h06, 8'($urandom), '0, 1'b0, 9'h000, 8'h00);
      do_reset(cause, 2);
      chk_rst();
      por = (cause == sfr_bank1_pkg::CAUSE_POR) || (cause == sfr_bank1_pkg::CAUSE_BROWNOUT);
      est = por ? 8'h18 : {3'b000, (cause == sfr_bank1_pkg::CAUSE_WDT) ? 1'b0 : st[4], st[3:0]};
      if (cause == sfr_bank1_pkg::CAUSE_BROWNOUT) pw = 2'b10;
      if (cause == sfr_bank1_pkg::CAUSE_POR) pw = 2'b00;
      chk(16'(cfg.status), 16'(est), "status after reset");
      chk(16'(cfg.intCtl), 16'(por ? 8'h00 : {7'h00, ib[0]}), "irq control after reset");
      chk(16'(cfg.pwrCause), 16'(pw), "reset cause after reset");
      access(1'b0, 7'h04, 8'h00, '0, 1'b0, 9'h000, por ? 8'h00 : p);
      st = est;
    end
    finish_test();
  end
endmodule
`default_nettype wire
